// [ths_defines.vh]
// Constants for the terminal host status exchange block
`ifndef THS_DEFINES_VH
`define THS_DEFINES_VH
`define THS_WORD_W 16
`define THS_TABLE_W 9
`define THS_NOTIFY_STROBE_BIT 11
`define THS_CTRL_SCREEN_BIT 15
`define THS_CTRL_HISTORY_BIT 5
`define THS_CTRL_REPORT_BIT 4
`define THS_CTRL_RESET 16'h8000
`define THS_NOTIFY_RESET 16'h0000
`define THS_CHANGED_RESET 16'h0000
`define THS_BCD_DIGITS 3
`endif

// [ths_bcd3.v]
// Binary table number to three BCD digits
`timescale 1ns/10ps
module ths_bcd3 (
   bin,
   bcd
);
   input wire [8:0] bin;
   output reg [11:0] bcd;
   integer i;
   reg [20:0] sh;
   always @* begin
      sh = 21'h0;
      sh[8:0] = bin;
      for (i = 0; i < 9; i = i + 1) begin
         if (sh[12:9] > 4'h4) sh[12:9] = sh[12:9] + 4'h3;
         if (sh[16:13] > 4'h4) sh[16:13] = sh[16:13] + 4'h3;
         if (sh[20:17] > 4'h4) sh[20:17] = sh[20:17] + 4'h3;
         sh = {sh[19:0], 1'b0};
      end
      bcd = sh[20:9];
   end
endmodule // ths_bcd3

// [ths_rise.v]
// Rising-edge detector for one control bit
`timescale 1ns/10ps
module ths_rise (
   mclk,
   resetn,
   ce,
   armed,
   level,
   rise
);
   input wire mclk;
   input wire resetn;
   input wire ce;
   input wire armed;
   input wire level;
   output wire rise;
   reg prev_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) prev_q <= 1'b0;
      else if (ce) prev_q <= level;
   end
   assign rise = armed & level & ~prev_q;
endmodule // ths_rise

// [ths_exchange.v]
// Terminal side of the host status exchange words
// Overview of operation
// - Numeral entry sets the notify strobe and posts the changed table number.
// - Changed table number is posted as three BCD digits.
// - Strobe returns to 0 once delivered to the host.
// - Control bit 15 low blanks the backlight, high lights it.
// - When blanked, bit 15 rising or a key press relights; a key press is lost while a change with bit 15 low is acted on.
// - Bit 5 rising prints display history once.
// - Bit 4 rising prints one daily report.
// - Control word ignored at start-up; act only on changes afterwards.
// - Device never writes the control word back.
// - Numeral strobe sits at bit 11 of the status word.
`timescale 1ns/10ps
`include "ths_defines.vh"
module ths_exchange (
   mclk,
   resetn,
   ce,
   startup_done,
   entry_valid,
   entry_table,
   key_press,
   notify_delivered,
   ctrl_write,
   ctrl_wdata,
   notify_word,
   changed_word,
   ctrl_word,
   backlight_on,
   history_print,
   report_print
);
   input wire mclk;
   input wire resetn;
   input wire ce;
   input wire startup_done;
   input wire entry_valid;
   input wire [8:0] entry_table;
   input wire key_press;
   input wire notify_delivered;
   input wire ctrl_write;
   input wire [15:0] ctrl_wdata;
   output reg [15:0] notify_word;
   output reg [15:0] changed_word;
   output reg [15:0] ctrl_word;
   output reg backlight_on;
   output reg history_print;
   output reg report_print;

   wire [11:0] bcd;
   wire hist_rise;
   wire rep_rise;
   wire scr_rise;
   reg armed_q;
   reg changed_q;
   reg strobe_d;

   ths_bcd3 u_bcd (
      .bin(entry_table),
      .bcd(bcd)
   );

   // Edges are judged against the last word seen, so only changes act
   ths_rise u_hist (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .armed(changed_q),
      .level(ctrl_word[`THS_CTRL_HISTORY_BIT]),
      .rise(hist_rise)
   );
   ths_rise u_rep (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .armed(changed_q),
      .level(ctrl_word[`THS_CTRL_REPORT_BIT]),
      .rise(rep_rise)
   );
   ths_rise u_scr (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .armed(changed_q),
      .level(ctrl_word[`THS_CTRL_SCREEN_BIT]),
      .rise(scr_rise)
   );

   // A new entry beats a delivery in the same cycle so no event is lost
   always @* begin
      strobe_d = notify_word[`THS_NOTIFY_STROBE_BIT];
      if (notify_delivered) strobe_d = 1'b0;
      if (entry_valid) strobe_d = 1'b1;
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         notify_word <= `THS_NOTIFY_RESET;
         changed_word <= `THS_CHANGED_RESET;
         ctrl_word <= `THS_CTRL_RESET;
         armed_q <= 1'b0;
         changed_q <= 1'b0;
         backlight_on <= 1'b1;
         history_print <= 1'b0;
         report_print <= 1'b0;
      end else if (ce) begin
         notify_word[`THS_NOTIFY_STROBE_BIT] <= strobe_d;
         if (entry_valid) begin
            changed_word <= {4'h0, bcd};
         end
         // Control word is only ever written by the host
         changed_q <= 1'b0;
         if (ctrl_write) begin
            ctrl_word <= ctrl_wdata;
            // Writes before start-up are stored but never acted on
            changed_q <= armed_q & (ctrl_wdata != ctrl_word);
         end
         if (startup_done) armed_q <= 1'b1;
         history_print <= hist_rise;
         report_print <= rep_rise;
         if (changed_q && !ctrl_word[`THS_CTRL_SCREEN_BIT]) begin
            backlight_on <= 1'b0;
         end else if (scr_rise || (key_press && armed_q)) begin
            backlight_on <= 1'b1;
         end
      end
   end
endmodule // ths_exchange

// [ths_exchange_checker.sv]
// Assertion checker for the status exchange
`timescale 1ns/10ps
module ths_checker(input wire mclk,resetn,ce,startup_done,entry_valid,key_press,notify_delivered,ctrl_write,
input wire [8:0] entry_table,input wire [15:0] ctrl_wdata,notify_word,changed_word,ctrl_word,
input wire backlight_on,history_print,report_print);
wire [15:0] b=16'(entry_table/100*256+entry_table%100/10*16+entry_table%10);
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
a_entry_sets: assert property (ce&&entry_valid |=> notify_word==16'h0800) else $error("strobe");
a_entry_bcd: assert property (ce&&entry_valid |=> changed_word==$past(b)) else $error("bcd");
a_strobe_clear: assert property (ce&&notify_delivered&&!entry_valid |=> !notify_word[11]) else $error("clr");
a_ctrl_hold: assert property (!(ce&&ctrl_write) |=> $stable(ctrl_word)) else $error("hold");
a_report_rise: assert property (report_print |-> $past(ctrl_word[4])&&!$past(ctrl_word[4],2)) else $error("rep");
a_history_rise: assert property (history_print |-> $past(ctrl_word[5])&&!$past(ctrl_word[5],2)) else $error("his");
a_startup_quiet: assert property (!startup_done |-> !history_print&&!report_print) else $error("early");
a_key_relight: assert property (ce&&key_press&&startup_done |-> ##[1:2] backlight_on) else $error("key");
a_blank_bit: assert property ($fell(backlight_on) |-> !ctrl_word[15]) else $error("blank");
c_report: cover property (report_print);
c_history: cover property (history_print);
c_blank: cover property ($fell(backlight_on));
endmodule // ths_checker

// [ths_host_model.sv]
// Host controller model for the exchange words
`timescale 1ns/10ps
module ths_host_model(input wire mclk,input wire [15:0] notify_word,changed_word,
output logic ctrl_write=0,notify_delivered=0,output logic [15:0] ctrl_wdata=16'h7FFF,seen=0);
logic [15:0] img=16'h8000;
logic stall=1;
always @(posedge mclk) begin
   #1 notify_delivered=0;
   // Reads the changed word on the strobe, then would fetch that table's word
   if (notify_word[11]&&!stall) begin
      seen=changed_word;
      notify_delivered=1;
   end
end
// Read-modify-write keeps the other control bits; data is invalid outside the write
task wr(input int n,input logic v);
   @(posedge mclk) #1 img[n]=v;
   ctrl_wdata=img;
   ctrl_write=1;
   @(posedge mclk) #1 ctrl_write=0;
   ctrl_wdata=~img;
   @(posedge mclk) #1;
endtask
endmodule // ths_host_model

// [tb_terminal_host_status_exchange.sv]
// Testbench for the terminal host status exchange
`timescale 1ns/10ps
module tb_terminal_host_status_exchange;
logic mclk=0,resetn=0,ce=1,startup_done=0,entry_valid=0,key_press=0;
logic [8:0] entry_table=0;
logic [15:0] np=0,nh=0;
wire [15:0] notify_word,changed_word,ctrl_word,ctrl_wdata,seen;
wire ctrl_write,notify_delivered,backlight_on,history_print,report_print;
int n_fail=0,tests_run=0;
always #5 mclk=~mclk;
always @(posedge mclk) begin np<=np+report_print; nh<=nh+history_print; end
ths_exchange uut(.*);
ths_host_model h(.*);
task chk(input logic [15:0] g,e);
   tests_run++;
   if (g!==e) begin n_fail++; $display("mismatch %0t got %h exp %h",$time,g,e); end
endtask
task complete_run;
   if (n_fail==0&&tests_run>0) $display("DONE - PASS");
   else $display("DONE - FAIL");
   $finish;
endtask
task t_entry;
   @(posedge mclk) #1 entry_valid=1;
   entry_table=9'd123;
   @(posedge mclk) #1 entry_table=9'd511;
   @(posedge mclk) #1 entry_valid=0;
   chk(changed_word,16'h0511);
   chk(notify_word,16'h0800);
   h.stall=0;
   repeat(3) @(posedge mclk);
   #1 chk(notify_word,16'h0000);
   chk(seen,16'h0511);
endtask
task t_ctrl;
   h.wr(4,1);
   h.wr(4,0);
   chk(np,16'h0000);
   startup_done=1;
   h.wr(4,1); h.wr(4,1); h.wr(4,0); h.wr(4,1);
   // The last print pulse lands in the counter one edge after the task returns
   repeat(2) @(posedge mclk);
   #1 chk(np,16'h0002);
   h.wr(5,1); h.wr(5,1);
   chk(nh,16'h0001);
   h.wr(15,0);
   chk(backlight_on,16'h0000);
   h.wr(15,1);
   chk(backlight_on,16'h0001);
   h.wr(15,0);
   chk(backlight_on,16'h0000);
   key_press=1;
   @(posedge mclk) #1 key_press=0;
   @(posedge mclk) #1 chk(backlight_on,16'h0001);
   chk(ctrl_word,16'h0030);
endtask
initial begin
   repeat(8) @(posedge mclk);
   #1 resetn=1;
   t_entry;
   t_ctrl;
   complete_run;
end
initial begin #20000; n_fail++; complete_run; end
endmodule // tb_terminal_host_status_exchange
bind ths_exchange ths_checker chk(.*);
